// >>> rtl/pin4_mux_pkg.sv
// Constants, types and carriers shared by the shared-pin logic
package pin4_mux_pkg;
   // Operating mode when the add bus is disabled
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_HDLC,
      MODE_MAPPER
   } op_mode_t;

   // Which role filled a stream word
   typedef enum logic {
      SRC_ADD_BUS,
      SRC_HDLC
   } word_src_t;

   // Samples of the pin packed per stream word
   localparam int unsigned PACK_BITS = 32;
   // Stream buffer depth in words
   localparam int unsigned FIFO_DEPTH = 32;
   // Half period of the byte clock, in system clocks
   localparam int unsigned HDLC_HALF_CYCLES = 4;
   // Synchroniser latency before a byte-clock sample is taken
   localparam int unsigned HDLC_SAMPLE_LAT = 2;
   // Counter value at which the byte clock rises
   localparam int unsigned HDLC_RISE_CNT = 1;

   // Reset values
   localparam logic [PACK_BITS-1:0] WORD_RST = 32'h0000_0000;
   localparam logic PIN_RST = 1'b0;

   typedef struct packed {
      word_src_t src;
      logic [PACK_BITS-1:0] data;
   } word_t;

   typedef struct packed {
      logic bit_strobe;
      logic oh_next;
   } framer_ctl_t;

   typedef struct packed {
      logic valid;
      logic payload;
   } payload_t;
endpackage : pin4_mux_pkg

// >>> rtl/stream_fifo.sv
// Synchronous stream FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
   parameter int unsigned WIDTH = 33,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wptr_ff;
   logic [AW:0] rptr_ff;
   logic [AW:0] nxt_wptr;
   logic [AW:0] nxt_rptr;
   logic full;
   logic empty;
   logic push;
   logic pop;

   always_comb begin
      empty = (wptr_ff == rptr_ff);
      full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
      push = in_valid_i && !full;
      pop = out_ready_i && !empty;
      nxt_wptr = push ? wptr_ff + (AW+1)'(1) : wptr_ff;
      nxt_rptr = pop ? rptr_ff + (AW+1)'(1) : rptr_ff;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
      end else begin
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
      end
   end

   // Storage has no reset; reads are gated by the empty flag
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wptr_ff[AW-1:0]] <= in_data_i;
      end
   end

   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem_ff[rptr_ff[AW-1:0]];
endmodule : stream_fifo
`default_nettype wire

// >>> rtl/shared_pin4_ch1.sv
// Role mux and capture logic behind the shared channel-1 bit-4 pin
`timescale 1ns/100ps
`default_nettype none
module shared_pin4_ch1 #(
   parameter int unsigned PACK = pin4_mux_pkg::PACK_BITS,
   parameter int unsigned DEPTH = pin4_mux_pkg::FIFO_DEPTH,
   parameter int unsigned HDLC_HALF = pin4_mux_pkg::HDLC_HALF_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic add_bus_ch1_clock_i,
   input wire logic add_bus_enable_i,
   input wire pin4_mux_pkg::op_mode_t mode_i,
   input wire logic pad_i,
   output logic pad_o,
   output logic pad_oe_o,
   output logic hdlc_tx_ch1_byte_clock_o,
   input wire pin4_mux_pkg::framer_ctl_t framer_i,
   input wire logic tx_serial_payload_ch1_i,
   output var pin4_mux_pkg::payload_t payload_o,
   output var pin4_mux_pkg::word_t word_o,
   output logic word_valid_o,
   input wire logic word_ready_i,
   input wire logic overrun_clear_i,
   output logic add_overrun_o
);
   localparam int unsigned CW = $clog2(PACK);
   localparam int unsigned DW = $clog2(2 * HDLC_HALF);
   localparam logic [CW-1:0] PACK_LAST = CW'(PACK - 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(2 * HDLC_HALF - 1);
   localparam logic [DW-1:0] DIV_HIGH = DW'(HDLC_HALF);
   localparam logic [DW-1:0] DIV_RISE = DW'(pin4_mux_pkg::HDLC_RISE_CNT);
   localparam logic [DW-1:0] DIV_SAMPLE =
      DW'(pin4_mux_pkg::HDLC_RISE_CNT + pin4_mux_pkg::HDLC_SAMPLE_LAT);

   // Role decode (system domain)
   logic role_add;
   logic role_hdlc;
   logic role_map;

   always_comb begin
      role_add = add_bus_enable_i;
      role_hdlc = !add_bus_enable_i && (mode_i == pin4_mux_pkg::MODE_HDLC);
      role_map = !add_bus_enable_i && (mode_i == pin4_mux_pkg::MODE_MAPPER);
   end

   // Add bus domain: falling edge of the bus clock
   logic lrst_meta_ff;
   logic lrst_n_ff;
   logic len_meta_ff;
   logic len_ff;
   logic lack_meta_ff;
   logic lack_ff;
   logic [PACK-1:0] lshift_ff;
   logic [CW-1:0] lcnt_ff;
   logic [PACK-1:0] lhold_ff;
   logic lreq_ff;
   logic ldrop_ff;
   logic [PACK-1:0] nxt_lshift;
   logic [CW-1:0] nxt_lcnt;
   logic [PACK-1:0] nxt_lhold;
   logic nxt_lreq;
   logic nxt_ldrop;
   logic ack_ff;

   // Reset, enable and acknowledge brought into the bus clock domain
   always_ff @(negedge add_bus_ch1_clock_i) begin
      lrst_meta_ff <= rst_n_i;
      lrst_n_ff <= lrst_meta_ff;
      len_meta_ff <= add_bus_enable_i;
      len_ff <= len_meta_ff;
      lack_meta_ff <= ack_ff;
      lack_ff <= lack_meta_ff;
   end

   always_comb begin
      nxt_lshift = lshift_ff;
      nxt_lcnt = lcnt_ff;
      nxt_lhold = lhold_ff;
      nxt_lreq = lreq_ff;
      nxt_ldrop = ldrop_ff;
      if (len_ff) begin
         nxt_lshift = {lshift_ff[PACK-2:0], pad_i};
         nxt_lcnt = lcnt_ff + CW'(1);
         if (lcnt_ff == PACK_LAST) begin
            nxt_lcnt = '0;
            // A word still unacknowledged means the buffer is stalled
            if (lreq_ff == lack_ff) begin
               nxt_lhold = {lshift_ff[PACK-2:0], pad_i};
               nxt_lreq = !lreq_ff;
            end else begin
               nxt_ldrop = !ldrop_ff;
            end
         end
      end else begin
         nxt_lcnt = '0;
      end
   end

   always_ff @(negedge add_bus_ch1_clock_i) begin
      if (!lrst_n_ff) begin
         lshift_ff <= pin4_mux_pkg::WORD_RST;
         lcnt_ff <= '0;
         lhold_ff <= pin4_mux_pkg::WORD_RST;
         lreq_ff <= 1'b0;
         ldrop_ff <= 1'b0;
      end else begin
         lshift_ff <= nxt_lshift;
         lcnt_ff <= nxt_lcnt;
         lhold_ff <= nxt_lhold;
         lreq_ff <= nxt_lreq;
         ldrop_ff <= nxt_ldrop;
      end
   end

   // System domain
   logic req_meta_ff;
   logic req_s_ff;
   logic drop_meta_ff;
   logic drop_s_ff;
   logic drop_seen_ff;
   logic pad_meta_ff;
   logic pad_s_ff;
   logic pay_meta_ff;
   logic pay_s_ff;

   always_ff @(posedge clk_i) begin
      req_meta_ff <= lreq_ff;
      req_s_ff <= req_meta_ff;
      drop_meta_ff <= ldrop_ff;
      drop_s_ff <= drop_meta_ff;
      pad_meta_ff <= pad_i;
      pad_s_ff <= pad_meta_ff;
      pay_meta_ff <= tx_serial_payload_ch1_i;
      pay_s_ff <= pay_meta_ff;
   end

   // Stream buffer hookup
   pin4_mux_pkg::word_t fifo_in;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic add_new;

   // Add bus handshake: the held word is stable until acknowledged
   logic nxt_ack;
   logic overrun_ff;
   logic nxt_overrun;

   // HDLC byte clock and sampling
   logic [DW-1:0] div_ff;
   logic hclk_ff;
   logic [PACK-1:0] hshift_ff;
   logic [CW-1:0] hcnt_ff;
   logic hpend_ff;
   logic [PACK-1:0] hword_ff;
   logic [DW-1:0] nxt_div;
   logic nxt_hclk;
   logic [PACK-1:0] nxt_hshift;
   logic [CW-1:0] nxt_hcnt;
   logic nxt_hpend;
   logic [PACK-1:0] nxt_hword;

   // Overhead indicator
   logic ind_ff;
   logic ohcur_ff;
   pin4_mux_pkg::payload_t pay_ff;
   logic nxt_ind;
   logic nxt_ohcur;
   pin4_mux_pkg::payload_t nxt_pay;

   always_comb begin
      add_new = role_add && (req_s_ff != ack_ff);
      nxt_ack = ack_ff;
      if (add_new && fifo_in_ready) begin
         nxt_ack = req_s_ff;
      end
      // A new drop wins over a clear in the same cycle
      nxt_overrun = overrun_ff;
      if (overrun_clear_i) begin
         nxt_overrun = 1'b0;
      end
      if (drop_s_ff != drop_seen_ff) begin
         nxt_overrun = 1'b1;
      end
   end

   always_comb begin
      nxt_div = div_ff;
      nxt_hshift = hshift_ff;
      nxt_hcnt = hcnt_ff;
      nxt_hpend = hpend_ff;
      nxt_hword = hword_ff;
      if (hpend_ff && fifo_in_ready) begin
         nxt_hpend = 1'b0;
      end
      if (!role_hdlc) begin
         nxt_div = '0;
         nxt_hcnt = '0;
      end else begin
         // Clock parks low at count zero while a word waits for room
         if (div_ff != '0 || !hpend_ff) begin
            nxt_div = (div_ff == DIV_LAST) ? '0 : div_ff + DW'(1);
         end
         if (div_ff == DIV_SAMPLE) begin
            // Value seen at the rise, after the two-stage synchroniser
            nxt_hshift = {hshift_ff[PACK-2:0], pad_s_ff};
            nxt_hcnt = hcnt_ff + CW'(1);
            if (hcnt_ff == PACK_LAST) begin
               nxt_hcnt = '0;
               nxt_hword = {hshift_ff[PACK-2:0], pad_s_ff};
               nxt_hpend = 1'b1;
            end
         end
      end
      nxt_hclk = role_hdlc && (nxt_div >= DIV_RISE) && (nxt_div <= DIV_HIGH);
   end

   always_comb begin
      nxt_ind = ind_ff;
      nxt_ohcur = ohcur_ff;
      nxt_pay = '0;
      if (!role_map) begin
         nxt_ind = 1'b0;
         nxt_ohcur = 1'b0;
      end else if (framer_i.bit_strobe) begin
         // Period now ending is dropped when it carried overhead
         nxt_pay.valid = !ohcur_ff;
         nxt_pay.payload = pay_s_ff;
         nxt_ohcur = ind_ff;
         nxt_ind = framer_i.oh_next;
      end
   end

   always_comb begin
      if (role_add) begin
         fifo_in.src = pin4_mux_pkg::SRC_ADD_BUS;
         fifo_in.data = lhold_ff;
         fifo_in_valid = add_new;
      end else begin
         fifo_in.src = pin4_mux_pkg::SRC_HDLC;
         fifo_in.data = hword_ff;
         fifo_in_valid = hpend_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
         drop_seen_ff <= 1'b0;
         overrun_ff <= 1'b0;
         div_ff <= '0;
         hclk_ff <= 1'b0;
         hshift_ff <= pin4_mux_pkg::WORD_RST;
         hcnt_ff <= '0;
         hpend_ff <= 1'b0;
         hword_ff <= pin4_mux_pkg::WORD_RST;
         ind_ff <= pin4_mux_pkg::PIN_RST;
         ohcur_ff <= 1'b0;
         pay_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         drop_seen_ff <= drop_s_ff;
         overrun_ff <= nxt_overrun;
         div_ff <= nxt_div;
         hclk_ff <= nxt_hclk;
         hshift_ff <= nxt_hshift;
         hcnt_ff <= nxt_hcnt;
         hpend_ff <= nxt_hpend;
         hword_ff <= nxt_hword;
         ind_ff <= nxt_ind;
         ohcur_ff <= nxt_ohcur;
         pay_ff <= nxt_pay;
      end
   end

   stream_fifo #(
      .WIDTH($bits(pin4_mux_pkg::word_t)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in),
      .out_valid_o(word_valid_o),
      .out_ready_i(word_ready_i),
      .out_data_o(word_o)
   );

   assign pad_o = ind_ff;
   assign pad_oe_o = role_map;
   assign hdlc_tx_ch1_byte_clock_o = hclk_ff;
   assign payload_o = pay_ff;
   assign add_overrun_o = overrun_ff;
endmodule : shared_pin4_ch1
`default_nettype wire

// >>> tb/shared_pin4_ch1_assertions.sv
// Checker for the shared channel-1 bit-4 pin block
`timescale 1ns/100ps
`default_nettype none
module shared_pin4_ch1_assertions (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic add_bus_enable_i,
   input wire pin4_mux_pkg::op_mode_t mode_i,
   input wire logic pad_o,
   input wire logic pad_oe_o,
   input wire logic hdlc_tx_ch1_byte_clock_o,
   input wire pin4_mux_pkg::framer_ctl_t framer_i,
   input wire pin4_mux_pkg::payload_t payload_o,
   input wire pin4_mux_pkg::word_t word_o,
   input wire logic word_valid_o,
   input wire logic word_ready_i,
   input wire logic overrun_clear_i,
   input wire logic add_overrun_o
);
   logic map_role, hdlc_role, strobe, bc, ind_done_ff, nxt_ind_done;
   assign map_role = !add_bus_enable_i && mode_i == pin4_mux_pkg::MODE_MAPPER;
   assign hdlc_role = !add_bus_enable_i && mode_i == pin4_mux_pkg::MODE_HDLC;
   assign strobe = framer_i.bit_strobe;
   assign bc = hdlc_tx_ch1_byte_clock_o;
   // Set when the period just ended carried the indicator
   always_comb nxt_ind_done = strobe ? pad_o : ind_done_ff;
   always_ff @(posedge clk_i) ind_done_ff <= rst_n_i ? nxt_ind_done : 1'b0;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence bc_high;
      bc [*4] ##1 !bc;
   endsequence
   sequence bc_low;
      !bc [*4];
   endsequence
   AST_OE_ROLE: assert property (pad_oe_o == map_role)
      else $error("driver enable wrong for role");
   AST_BC_ROLE: assert property (!hdlc_role |=> !bc)
      else $error("byte clock runs outside HDLC role");
   AST_BC_HIGH: assert property ($rose(bc) |-> bc_high)
      else $error("byte clock high phase wrong");
   AST_BC_LOW: assert property ($fell(bc) && hdlc_role |-> bc_low)
      else $error("byte clock low phase short");
   AST_IND_SET: assert property (
      map_role && strobe |=> pad_o == $past(framer_i.oh_next))
      else $error("indicator not set from strobe");
   AST_IND_HOLD: assert property (map_role && !strobe |=> $stable(pad_o))
      else $error("indicator moved between strobes");
   AST_PL_CAUSE: assert property (payload_o.valid |-> $past(strobe))
      else $error("payload without strobe");
   AST_PL_DROP: assert property (
      map_role && strobe && ind_done_ff |=> !payload_o.valid)
      else $error("overhead bit passed as payload");
   AST_WORD_HOLD: assert property (
      word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
      else $error("word changed before pop");
   AST_OVR_KEEP: assert property (add_overrun_o && !overrun_clear_i |=> add_overrun_o)
      else $error("overrun flag lost");
endmodule : shared_pin4_ch1_assertions
bind shared_pin4_ch1 shared_pin4_ch1_assertions shared_pin4_ch1_assertions_i (
   .clk_i, .rst_n_i, .add_bus_enable_i, .mode_i, .pad_o, .pad_oe_o,
   .hdlc_tx_ch1_byte_clock_o, .framer_i, .payload_o, .word_o, .word_valid_o,
   .word_ready_i, .overrun_clear_i, .add_overrun_o
);
`default_nettype wire

// >>> tb/term_equip_model.sv
// Terminal equipment model: add bus source and HDLC byte source
`timescale 1ns/100ps
`default_nettype none
module term_equip_model (
   input wire logic hdlc_i,
   input wire logic byte_clock_i,
   output logic link_clk_o,
   output logic pad_o
);
   localparam logic [31:0] ADD_PAT = 32'h0000_00f3;
   localparam logic [31:0] HDLC_PAT = 32'hc35a_0f96;
   logic add_bit = 1'b0;
   int unsigned ai = 0;
   int unsigned hi = 0;
   logic lclk = 1'b0;
   // Runs free: the link-side reset resync needs its edges
   always #3 lclk = ~lclk;
   assign link_clk_o = lclk;
   // Bit valid across the sampling fall only, inverted once hold runs out
   always @(posedge link_clk_o) begin
      #1;
      add_bit = ADD_PAT[31 - ai];
      ai = (ai + 1) % 32;
   end
   always @(negedge link_clk_o) #1 add_bit = ~add_bit;
   // New HDLC bit after each byte clock fall, steady over the next rise
   always @(negedge byte_clock_i or negedge hdlc_i) begin
      hi = hdlc_i ? (hi + 1) % 32 : 0;
   end
   // Indicator output left unwatched
   assign pad_o = hdlc_i ? HDLC_PAT[31 - hi] : add_bit;
endmodule : term_equip_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the shared channel-1 bit-4 pin block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam logic [31:0] ADD_PAT = 32'h0000_00f3;
   localparam logic [31:0] HDLC_PAT = 32'hc35a_0f96;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic add_bus_enable_i = 1'b0;
   pin4_mux_pkg::op_mode_t mode_i = pin4_mux_pkg::MODE_IDLE;
   pin4_mux_pkg::framer_ctl_t framer_i = '0;
   logic tx_serial_payload_ch1_i = 1'b1;
   logic word_ready_i = 1'b0;
   logic overrun_clear_i = 1'b0;
   logic add_bus_ch1_clock_i, eq_pad, pad_i, pad_o, pad_oe_o, hdlc_tx_ch1_byte_clock_o;
   logic word_valid_o, add_overrun_o, hdlc_role;
   pin4_mux_pkg::payload_t payload_o;
   pin4_mux_pkg::word_t word_o;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   assign pad_i = pad_oe_o ? pad_o : eq_pad;
   assign hdlc_role = !add_bus_enable_i && mode_i == pin4_mux_pkg::MODE_HDLC;
   always #12.5 clk_i = ~clk_i;
   shared_pin4_ch1 shared_pin4_ch1_i (
      .clk_i, .rst_n_i, .add_bus_ch1_clock_i, .add_bus_enable_i, .mode_i, .pad_i, .pad_o,
      .pad_oe_o, .hdlc_tx_ch1_byte_clock_o, .framer_i, .tx_serial_payload_ch1_i, .payload_o,
      .word_o, .word_valid_o, .word_ready_i, .overrun_clear_i, .add_overrun_o
   );
   term_equip_model term_equip_model_i (
      .hdlc_i(hdlc_role), .byte_clock_i(hdlc_tx_ch1_byte_clock_o),
      .link_clk_o(add_bus_ch1_clock_i), .pad_o(eq_pad)
   );
   task automatic chk1(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk1
   task automatic chkw(input pin4_mux_pkg::word_t got, input pin4_mux_pkg::word_t exp,
         input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s %h", $time, msg, got);
      end
   endtask : chkw
   task automatic stop_test;
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   // Fill the buffer past its depth, then drain it
   task automatic add_bus_test;
      logic [31:0] rot;
      int n;
      rot = 32'h0;
      n = 0;
      add_bus_enable_i <= 1'b1;
      repeat (400) @(posedge clk_i);
      #1;
      chk1(pad_oe_o, 1'b0, "driver on in add bus role");
      chk1(add_overrun_o, 1'b1, "full buffer not flagged");
      @(posedge clk_i);
      add_bus_enable_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      word_ready_i <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         #1;
         if (word_valid_o === 1'b1) begin
            // Word alignment is free; any rotation of the stream is accepted once
            for (int r = 0; r < 32 && n == 0; r++)
               if (32'({ADD_PAT, ADD_PAT} >> r) === word_o.data) rot = word_o.data;
            chkw(word_o, {pin4_mux_pkg::SRC_ADD_BUS, rot}, "add bus word");
            n++;
         end
         @(posedge clk_i);
      end
      word_ready_i <= 1'b0;
      overrun_clear_i <= 1'b1;
      chk1(n inside {32, 33}, 1'b1, "buffer depth");
      @(posedge clk_i);
      overrun_clear_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk1(add_overrun_o, 1'b0, "overrun not cleared");
      @(posedge clk_i);
   endtask : add_bus_test
   task automatic hdlc_test;
      int t0;
      mode_i <= pin4_mux_pkg::MODE_HDLC;
      @(posedge hdlc_tx_ch1_byte_clock_o);
      t0 = cyc;
      @(posedge hdlc_tx_ch1_byte_clock_o);
      chk1(cyc - t0 == 2 * pin4_mux_pkg::HDLC_HALF_CYCLES, 1'b1, "byte clock period");
      chk1(pad_oe_o, 1'b0, "driver on in HDLC role");
      for (int i = 0; i < 300 && word_valid_o !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      chkw(word_o, {pin4_mux_pkg::SRC_HDLC, HDLC_PAT}, "HDLC word");
      @(negedge hdlc_tx_ch1_byte_clock_o);
      @(posedge clk_i);
      mode_i <= pin4_mux_pkg::MODE_MAPPER;
      word_ready_i <= 1'b1;
   endtask : hdlc_test
   // Indicator before strobe 3; the bit ending at strobe 4 is dropped
   task automatic mapper_test;
      for (int s = 0; s < 6; s++) begin
         // Two edges for the payload synchroniser before the strobe
         tx_serial_payload_ch1_i <= s[0];
         repeat (2) @(posedge clk_i);
         framer_i <= '{bit_strobe: 1'b1, oh_next: s == 2};
         @(posedge clk_i);
         framer_i <= '0;
         #1;
         chk1(pad_o, s == 2, "indicator level");
         chk1(payload_o.valid, s != 4, "payload valid");
         if (s != 4) chk1(payload_o.payload, s[0], "payload bit");
         chk1(pad_oe_o, 1'b1, "driver off in indicator role");
         @(posedge clk_i);
      end
   endtask : mapper_test
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      add_bus_test();
      hdlc_test();
      mapper_test();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
